// file: hdl/dspacc_core.sv
// Accumulator datapath with saturation, rounding, store clipping and register slave.
`timescale 1ns/1ns
// Function
// - Adder adds true data, subtracts complemented data.
// - Guard flag set when bits 39..32 differ.
// - Guard flags rewritten on every adder pass.
// - Guard overflow with enable raises warning trap.
// - Clip flags sticky, cleared only by software.
// - Clip flag marks bit 31/39 overflow.
// - Unsaturated catastrophic overflow traps when enabled.
// - Status shows OR of guard and clip flags.
// - Saturation uses result, flags, enables, width select.
// - 40-bit mode loads extreme 40-bit values.
// - 32-bit mode loads 1.31 limits, no guard flags.
// - Without saturation accumulator wraps, clip flag set.
// - Plain MAC class writes back non-target word.
// - Write-back direct or indirect with post-increment.
// - Round stage selects mode or truncates.
// - Conventional rounding increments on low word >= 0x8000.
// - Convergent tie increments only when bit 16 set.
// - Stores truncated or rounded; write-back always rounded.
// - Store clipping limits to 1.15 range, sign bit 39.
// - Without store clipping data pass unmodified.
// - One-cycle shift up to 31 bits, signed amount.
// - Forty-bit shifter with X bus placement.
// - Per-accumulator saturation enables act independently.
module dspacc_core (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Operation request from the instruction sequencer.
	input wire dspacc_pkg::dspacc_op_t op,
	// Results towards the X bus and the shift consumer, then the trap request and status flags.
	output dspacc_pkg::dspacc_xw_t xw,
	output dspacc_pkg::dspacc_shift_t shift_out,
	output logic arith_trap_req,
	output logic [5:0] status_flags,
	// AXI4-Lite write channels.
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read channels.
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	import dspacc_pkg::*;

	// ==========================================================================
	// State and wires.
	// ==========================================================================
	logic [7:0] cfg; // Core configuration: saturation, width, store clip, rounding.
	logic [2:0] trap_en; // Trap control enables.
	logic [39:0] acc_a; // Accumulator A.
	logic [39:0] acc_b; // Accumulator B.
	logic [15:0] wb_ptr; // Write-back pointer.
	logic aw_full; // Write address held.
	logic w_full; // Write data held.
	logic [7:0] waddr; // Held write address.
	logic [31:0] wdata_q; // Held write data.
	logic [3:0] wstrb_q; // Held write strobes.
	logic aw_take, w_take, do_write, b_done, ar_take;
	logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
	logic wr_hit, rd_hit;
	logic [31:0] rd_data;
	logic alu_go, is_sub, sat_en, width32;
	logic [39:0] tgt, other, a_side, b_side, next_acc;
	logic [40:0] sum41; // One extra bit keeps the true sign past bit 39.
	logic ovf39, ovf31, guard_ovf, sum_neg;
	logic guard_hit, clip_hit, fatal_hit;
	logic clr_a, clr_b;
	logic [5:0] next_status;
	logic wb_go, st_go, do_round;
	logic [39:0] store_src;
	logic [15:0] store_word;
	logic [39:0] shift_wide;

	// ==========================================================================
	// Round and store clipping helpers.
	// ==========================================================================
	// The tie case differs between the two modes; the sum keeps the guard byte for clipping.
	function automatic logic [23:0] round_word(input logic [39:0] acc, input logic en, input logic conv);
		logic inc;
		inc = 1'b0;
		if (en && conv && acc[15:0] == ROUND_HALF) begin
			inc = acc[16];
		end else if (en) begin
			inc = acc[15];
		end
		return acc[39:16] + {23'h00_0000, inc};
	endfunction

	// Clipping never touches the accumulator itself, only the word on its way out.
	function automatic logic [15:0] clip_word(input logic [23:0] val, input logic neg, input logic en);
		if (en && !neg && val > STORE_POS_LIMIT) begin
			return Q15_MAX;
		end else if (en && neg && val < STORE_NEG_LIMIT) begin
			return Q15_MIN;
		end
		return val[15:0];
	endfunction

	// ==========================================================================
	// Adder, overflow detection and saturation.
	// ==========================================================================
	assign alu_go = op.valid && (op.kind == OP_ADD || op.kind == OP_SUB);
	assign is_sub = (op.kind == OP_SUB);
	assign tgt = op.target_b ? acc_b : acc_a;
	assign other = op.target_b ? acc_a : acc_b;
	// Each accumulator has its own enable; the width select is shared.
	assign sat_en = op.target_b ? cfg[CFG_ACC_B_CLIP_ENABLE_BIT] : cfg[CFG_ACC_A_CLIP_ENABLE_BIT];
	assign width32 = cfg[CFG_WIDTH_BIT];

	// Subtraction feeds complemented data with the borrow-in held inactive (carry high).
	always_comb begin
		a_side = op.zero_in ? 40'h0 : tgt;
		b_side = is_sub ? ~op.operand : op.operand;
		sum41 = {a_side[39], a_side} + {b_side[39], b_side} + {40'h0, is_sub};
		sum_neg = sum41[40];
		ovf39 = sum41[40] ^ sum41[39];
		ovf31 = ~((&sum41[40:31]) | ~(|sum41[40:31]));
		guard_ovf = ~((&sum41[39:32]) | ~(|sum41[39:32]));
	end

	// Mode decision: 40-bit saturation, 32-bit saturation, or wrap with catastrophic flag.
	always_comb begin
		next_acc = sum41[39:0];
		guard_hit = guard_ovf;
		clip_hit = 1'b0;
		fatal_hit = 1'b0;
		if (sat_en && !width32) begin
			clip_hit = ovf39;
			if (ovf39) begin
				next_acc = sum_neg ? SAT40_NEG : SAT40_POS;
			end
		end else if (sat_en) begin
			guard_hit = 1'b0;
			clip_hit = ovf31;
			if (ovf31) begin
				next_acc = sum_neg ? SAT32_NEG : SAT32_POS;
			end
		end else begin
			clip_hit = ovf39;
			fatal_hit = ovf39;
		end
	end

	// Accumulators only change on an adder pass; stores and shifts leave them alone.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_a <= 40'h0;
			acc_b <= 40'h0;
		end else if (alu_go && op.target_b) begin
			acc_b <= next_acc;
		end else if (alu_go) begin
			acc_a <= next_acc;
		end
	end

	// ==========================================================================
	// Status flags and trap request.
	// ==========================================================================
	assign clr_a = do_write && waddr == OFS_STAT && wstrb_q[0] && wdata_q[STAT_CLIP_A_BIT];
	assign clr_b = do_write && waddr == OFS_STAT && wstrb_q[0] && wdata_q[STAT_CLIP_B_BIT];

	// The clear is applied first so that a same-cycle overflow still leaves the flag set.
	always_comb begin
		next_status = status_flags;
		if (alu_go && !op.target_b) begin
			next_status[STAT_GUARD_A_BIT] = guard_hit;
		end
		if (alu_go && op.target_b) begin
			next_status[STAT_GUARD_B_BIT] = guard_hit;
		end
		if (clr_a) begin
			next_status[STAT_CLIP_A_BIT] = 1'b0;
		end
		if (clr_b) begin
			next_status[STAT_CLIP_B_BIT] = 1'b0;
		end
		if (alu_go && !op.target_b && clip_hit) begin
			next_status[STAT_CLIP_A_BIT] = 1'b1;
		end
		if (alu_go && op.target_b && clip_hit) begin
			next_status[STAT_CLIP_B_BIT] = 1'b1;
		end
		next_status[STAT_EITHER_GUARD_BIT] = next_status[STAT_GUARD_A_BIT] | next_status[STAT_GUARD_B_BIT];
		next_status[STAT_EITHER_CLIP_BIT] = next_status[STAT_CLIP_A_BIT] | next_status[STAT_CLIP_B_BIT];
	end

	// Flags are held in the status output register itself.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flags <= STAT_RESET;
		end else begin
			status_flags <= next_status;
		end
	end

	// One trap pulse per offending adder pass; the sequencer decides what to do with it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arith_trap_req <= 1'b0;
		end else begin
			arith_trap_req <= alu_go && ((guard_hit && trap_en[op.target_b ? TRAP_GB_BIT : TRAP_GA_BIT])
				|| (fatal_hit && trap_en[TRAP_FATAL_BIT]));
		end
	end

	// ==========================================================================
	// Round, store clipping and write-back.
	// ==========================================================================
	// Write-back reads the non-target accumulator before this pass updates anything.
	assign wb_go = alu_go && op.wb_en && op.cls == CLS_MAC;
	assign st_go = op.valid && (op.kind == OP_STORE || op.kind == OP_STORE_RND);
	assign store_src = st_go ? tgt : other;
	assign do_round = wb_go || op.kind == OP_STORE_RND;
	assign store_word = clip_word(round_word(store_src, do_round, cfg[CFG_RND_BIT]), store_src[39], cfg[CFG_STORE_CLIP_ENABLE_BIT]);

	// Hardware pointer updates take precedence over a software write in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xw <= '0;
			wb_ptr <= WBPTR_RESET;
		end else begin
			xw.valid <= 1'b0;
			if (st_go) begin
				xw <= {1'b1, op.store_addr, store_word};
			end else if (wb_go && op.wb_indirect) begin
				xw <= {1'b1, wb_ptr, store_word};
				wb_ptr <= wb_ptr + WB_STEP;
			end else if (wb_go) begin
				wb_ptr <= store_word;
			end else if (do_write && waddr == OFS_WBPTR) begin
				if (wstrb_q[0]) begin
					wb_ptr[7:0] <= wdata_q[7:0];
				end
				if (wstrb_q[1]) begin
					wb_ptr[15:8] <= wdata_q[15:8];
				end
			end
		end
	end

	// ==========================================================================
	// Barrel shifter.
	// ==========================================================================
	dspacc_shifter u_shifter (
		.acc_src(tgt),
		.xbus_data(op.xbus_data),
		.from_xbus(op.shift_from_xbus),
		.amt(op.shift_amt),
		.arith(op.shift_arith),
		.result(shift_wide)
	);

	// The whole shift completes in the cycle it is issued; the narrow word suits MCU shifts.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_out <= '0;
		end else begin
			shift_out.valid <= op.valid && op.kind == OP_SHIFT;
			shift_out.data <= shift_wide;
			shift_out.word <= (op.shift_amt > 0) ? shift_wide[31:16] : shift_wide[15:0];
		end
	end

	// ==========================================================================
	// AXI4-Lite slave.
	// ==========================================================================
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign b_done = s_axi_bvalid && s_axi_bready;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign next_aw_full = (aw_full || aw_take) && !do_write;
	assign next_w_full = (w_full || w_take) && !do_write;
	assign next_bvalid = (s_axi_bvalid && !b_done) || do_write;
	assign next_rvalid = (s_axi_rvalid && !s_axi_rready) || ar_take;
	// Accumulators are read-only here; writes to them answer with an error.
	assign wr_hit = waddr inside {OFS_CFG, OFS_TRAP, OFS_STAT, OFS_WBPTR};

	// Address and data are taken independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_bvalid <= next_bvalid;
			s_axi_awready <= !next_aw_full && !next_bvalid;
			s_axi_wready <= !next_w_full && !next_bvalid;
			if (do_write) begin
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Capture registers need no reset; they are only read once both halves have arrived.
	always_ff @(posedge aclk) begin
		if (aw_take) begin
			waddr <= s_axi_awaddr;
		end
		if (w_take) begin
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end
	end

	// Configuration and trap enables; every field lives in byte lane zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= CFG_RESET;
			trap_en <= TRAP_RESET;
		end else if (do_write && wstrb_q[0]) begin
			if (waddr == OFS_CFG) begin
				cfg <= wdata_q[7:0] & CFG_MASK;
			end
			if (waddr == OFS_TRAP) begin
				trap_en <= wdata_q[2:0];
			end
		end
	end

	// Read decode; unmapped addresses read zero with an error response.
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			OFS_CFG: rd_data = {24'h00_0000, cfg};
			OFS_TRAP: rd_data = {29'h0, trap_en};
			OFS_STAT: rd_data = {26'h0, status_flags};
			OFS_ACCA_LO: rd_data = acc_a[31:0];
			OFS_ACCA_HI: rd_data = {24'h00_0000, acc_a[39:32]};
			OFS_ACCB_LO: rd_data = acc_b[31:0];
			OFS_ACCB_HI: rd_data = {24'h00_0000, acc_b[39:32]};
			OFS_WBPTR: rd_data = {16'h0000, wb_ptr};
			default: begin
				rd_data = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data are sampled when the address is taken and held until accepted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (ar_take) begin
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ==========================================================================
	// Assertions.
	// ==========================================================================
	a_sat40_value: assert property (
		@(posedge aclk) disable iff (!aresetn)
		alu_go && !op.target_b && cfg[CFG_ACC_A_CLIP_ENABLE_BIT] && !width32 && ovf39 && !sum_neg
		|=> acc_a == SAT40_POS && status_flags[STAT_CLIP_A_BIT])
		else $error("Accumulator A missed positive 40-bit saturation.");
	a_sat32_noguard: assert property (
		@(posedge aclk) disable iff (!aresetn)
		alu_go && op.target_b && cfg[CFG_ACC_B_CLIP_ENABLE_BIT] && width32
		|=> !status_flags[STAT_GUARD_B_BIT] && (!$past(ovf31) || acc_b == SAT32_POS || acc_b == SAT32_NEG))
		else $error("Accumulator B misbehaved in 32-bit saturation.");
	a_wrap_catastro: assert property (
		@(posedge aclk) disable iff (!aresetn)
		alu_go && !op.target_b && !cfg[CFG_ACC_A_CLIP_ENABLE_BIT] && ovf39
		|=> acc_a == $past(sum41[39:0]) && status_flags[STAT_CLIP_A_BIT] && status_flags[STAT_EITHER_CLIP_BIT])
		else $error("Accumulator A did not wrap with clip flag set.");
	a_clip_sticky: assert property (
		@(posedge aclk) disable iff (!aresetn)
		$fell(status_flags[STAT_CLIP_A_BIT]) |-> $past(clr_a))
		else $error("Clip flag A cleared without a software write.");
	a_fatal_trap: assert property (
		@(posedge aclk) disable iff (!aresetn)
		alu_go && !sat_en && ovf39 && trap_en[TRAP_FATAL_BIT] |=> arith_trap_req ##1 !arith_trap_req || alu_go)
		else $error("Catastrophic overflow raised no trap.");
	a_guard_trap: assert property (
		@(posedge aclk) disable iff (!aresetn)
		alu_go && !op.target_b && guard_hit && trap_en[TRAP_GA_BIT]
		|=> arith_trap_req && status_flags[STAT_GUARD_A_BIT] && status_flags[STAT_EITHER_GUARD_BIT])
		else $error("Guard overflow on A raised no trap.");
	a_wb_postinc: assert property (
		@(posedge aclk) disable iff (!aresetn)
		wb_go && op.wb_indirect |=> xw.valid && wb_ptr == $past(wb_ptr) + WB_STEP && xw.addr == $past(wb_ptr))
		else $error("Indirect write-back did not store and advance the pointer.");
	a_round_conv: assert property (
		@(posedge aclk) disable iff (!aresetn)
		st_go && op.kind == OP_STORE_RND && !cfg[CFG_RND_BIT] && !cfg[CFG_STORE_CLIP_ENABLE_BIT]
		|=> xw.valid && xw.data == $past(tgt[31:16]) + {15'h0, $past(tgt[15])})
		else $error("Conventional rounded store gave a wrong word.");
	a_clear_loses: assert property (
		@(posedge aclk) disable iff (!aresetn)
		clr_b && alu_go && op.target_b && clip_hit |=> status_flags[STAT_CLIP_B_BIT])
		else $error("Software clear overrode a new clip event.");
endmodule // dspacc_core

// file: hdl/dspacc_pkg.sv
// Shared constants, encodings and carrier types of the accumulator datapath.
package dspacc_pkg;
	// ==========================================================================
	// Register map (byte addresses on the AXI4-Lite slave).
	// ==========================================================================
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_TRAP = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_ACCA_LO = 8'h0C;
	localparam logic [7:0] OFS_ACCA_HI = 8'h10;
	localparam logic [7:0] OFS_ACCB_LO = 8'h14;
	localparam logic [7:0] OFS_ACCB_HI = 8'h18;
	localparam logic [7:0] OFS_WBPTR = 8'h1C;
	// ==========================================================================
	// Field positions and reset values.
	// ==========================================================================
	localparam int CFG_ACC_A_CLIP_ENABLE_BIT = 7;
	localparam int CFG_ACC_B_CLIP_ENABLE_BIT = 6;
	localparam int CFG_STORE_CLIP_ENABLE_BIT = 5;
	localparam int CFG_WIDTH_BIT = 4;
	localparam int CFG_RND_BIT = 1;
	localparam logic [7:0] CFG_MASK = 8'hF2;
	localparam logic [7:0] CFG_RESET = 8'h20;
	localparam int TRAP_GA_BIT = 0;
	localparam int TRAP_GB_BIT = 1;
	localparam int TRAP_FATAL_BIT = 2;
	localparam logic [2:0] TRAP_RESET = 3'h0;
	localparam int STAT_GUARD_A_BIT = 0;
	localparam int STAT_GUARD_B_BIT = 1;
	localparam int STAT_CLIP_A_BIT = 2;
	localparam int STAT_CLIP_B_BIT = 3;
	localparam int STAT_EITHER_GUARD_BIT = 4;
	localparam int STAT_EITHER_CLIP_BIT = 5;
	localparam logic [5:0] STAT_RESET = 6'h00;
	localparam logic [15:0] WBPTR_RESET = 16'h0000;
	// ==========================================================================
	// Saturation limits, rounding and store clipping values.
	// ==========================================================================
	localparam logic [39:0] SAT40_POS = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
	localparam logic [39:0] SAT32_POS = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT32_NEG = 40'h00_8000_0000;
	localparam logic [15:0] ROUND_HALF = 16'h8000;
	localparam logic [23:0] STORE_POS_LIMIT = 24'h00_7FFF;
	localparam logic [23:0] STORE_NEG_LIMIT = 24'hFF_8000;
	localparam logic [15:0] Q15_MAX = 16'h7FFF;
	localparam logic [15:0] Q15_MIN = 16'h8000;
	localparam logic [15:0] WB_STEP = 16'h0002;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ==========================================================================
	// Operation encodings and carriers.
	// ==========================================================================
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ADD = 3'b001,
		OP_SUB = 3'b010,
		OP_STORE = 3'b011,
		OP_STORE_RND = 3'b100,
		OP_SHIFT = 3'b101
	} dspacc_op_kind_t;
	typedef enum logic [2:0] {
		CLS_MAC = 3'b000,
		CLS_MPY = 3'b001,
		CLS_MPY_NEG = 3'b010,
		CLS_SQDIFF = 3'b011,
		CLS_SQDIFF_ACC = 3'b100
	} dspacc_class_t;
	typedef struct packed {
		logic valid;
		dspacc_op_kind_t kind;
		dspacc_class_t cls;
		logic target_b;
		logic zero_in;
		logic [39:0] operand;
		logic wb_en;
		logic wb_indirect;
		logic [15:0] store_addr;
		logic signed [5:0] shift_amt;
		logic shift_from_xbus;
		logic shift_arith;
		logic [15:0] xbus_data;
	} dspacc_op_t;
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
	} dspacc_xw_t;
	typedef struct packed {
		logic valid;
		logic [39:0] data;
		logic [15:0] word;
	} dspacc_shift_t;
endpackage

// file: hdl/dspacc_shifter.sv
// Forty-bit signed-amount barrel shifter of the accumulator datapath.
`timescale 1ns/1ns
module dspacc_shifter (
	// Operand sources.
	input wire logic [39:0] acc_src,
	input wire logic [15:0] xbus_data,
	input wire logic from_xbus,
	// Shift control; positive amounts shift right.
	input wire logic signed [5:0] amt,
	input wire logic arith,
	// Result.
	output logic [39:0] result
);
	logic [39:0] operand;
	logic [4:0] mag;
	logic [7:0] ext;

	// X bus data sits in the middle word for right shifts and at the bottom for left shifts.
	always_comb begin
		ext = (arith && xbus_data[15]) ? 8'hFF : 8'h00;
		mag = (amt < 0) ? 5'(-amt) : 5'(amt);
		if (!from_xbus) begin
			operand = acc_src;
		end else if (amt > 0) begin
			operand = {ext, xbus_data, 16'h0000};
		end else begin
			operand = {24'h00_0000, xbus_data};
		end
		if (amt > 0) begin
			result = arith ? 40'($signed(operand) >>> mag) : (operand >> mag);
		end else begin
			result = operand << mag;
		end
	end
endmodule // dspacc_shifter

// file: testbench/dspacc_xbus_model.sv
// Far-side X bus model that takes every data-space write from the datapath.
`timescale 1ns/1ns
module dspacc_xbus_model (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write strobe from the datapath.
	input wire dspacc_pkg::dspacc_xw_t xw,
	// Last write taken.
	output logic [15:0] last_addr,
	output logic [15:0] last_data
);
	import dspacc_pkg::*;
	// ==========================================================================
	// Capture; the bus has no wait states, so a write is taken in its only cycle.
	// ==========================================================================
	always @(posedge aclk) begin
		if (!aresetn) begin
			last_addr <= 16'h0000;
			last_data <= 16'h0000;
		end else if (xw.valid === 1'b1) begin
			last_addr <= xw.addr;
			last_data <= xw.data;
		end
	end
endmodule // dspacc_xbus_model

// file: testbench/testbench.sv
// Self-checking bench for the accumulator datapath.
`timescale 1ns/1ns
module testbench;
	import dspacc_pkg::*;
	// ==========================================================================
	// Signals and the table of store cases.
	// ==========================================================================
	typedef struct {logic [7:0] cfg; logic [39:0] acc; dspacc_op_kind_t k; logic [15:0] exp;} dspacc_row_t;
	logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr, arr, trap;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd, rdat;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] stat;
	logic [15:0] la, ld;
	dspacc_op_t op;
	dspacc_xw_t xw;
	dspacc_shift_t sh;
	int fail_count, n_compared;
	// Rounding ties, truncation and store clipping at both limits.
	dspacc_row_t rows [9] = '{'{8'h00, 40'h00_1234_8000, OP_STORE_RND, 16'h1235},
		'{8'h00, 40'h00_1234_7FFF, OP_STORE_RND, 16'h1234}, '{8'h02, 40'h00_1234_8000, OP_STORE_RND, 16'h1234},
		'{8'h02, 40'h00_1235_8000, OP_STORE_RND, 16'h1236}, '{8'h02, 40'h00_1234_8001, OP_STORE_RND, 16'h1235},
		'{8'h00, 40'h00_1234_FFFF, OP_STORE, 16'h1234}, '{8'h20, 40'h01_0000_0000, OP_STORE, 16'h7FFF},
		'{8'h20, 40'hFE_0000_0000, OP_STORE, 16'h8000}, '{8'h00, 40'h01_2345_0000, OP_STORE, 16'h2345}};
	dspacc_core DUT (.aclk(aclk), .aresetn(aresetn), .op(op), .xw(xw), .shift_out(sh), .arith_trap_req(trap),
		.status_flags(stat), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
	dspacc_xbus_model xbus (.aclk(aclk), .aresetn(aresetn), .xw(xw), .last_addr(la), .last_data(ld));
	// The clock toggles every half period of 50 ns.
	always #50 aclk = ~aclk;
	// ==========================================================================
	// Tasks: compare, bus cycles, one operation, verdict.
	// ==========================================================================
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask
	// Address and data go out together; each is dropped at its own ready.
	// The waits have no limit of their own; only the watchdog ends a hang.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{awv, wv, br} <= 3'b111;
		awa <= a;
		wd <= d;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (bv !== 1'b1);
		br <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		{arv, rr} <= 2'b11;
		ara <= a;
		do begin
			@(posedge aclk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rr <= 1'b0;
		rdat = rd;
		resp = rresp;
	endtask
	// Effects are looked at just after the edge that takes the operation.
	task automatic run_op(input dspacc_op_kind_t k, input logic [39:0] d, input logic z,
		input logic signed [5:0] amt, input logic wb);
		@(posedge aclk);
		op.valid <= 1'b1;
		op.kind <= k;
		op.operand <= d;
		op.zero_in <= z;
		op.shift_amt <= amt;
		op.wb_en <= wb;
		op.wb_indirect <= wb;
		@(posedge aclk);
		op.valid <= 1'b0;
		#1;
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================================================
	// Main sequence and watchdog.
	// ==========================================================================
	initial begin
		{aclk, aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
		op = '0;
		op.store_addr = 16'h0040;
		op.shift_from_xbus = 1'b1;
		op.xbus_data = 16'h1230;
		fail_count = 0;
		n_compared = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axr(OFS_CFG);
		chk(rdat, CFG_RESET);
		axr(OFS_STAT);
		chk(rdat, 40'h00_0000_0000);
		$display("reset test done");
		foreach (rows[i]) begin
			axw(OFS_CFG, {24'h00_0000, rows[i].cfg});
			run_op(OP_ADD, rows[i].acc, 1'b1, 6'sd0, 1'b0);
			run_op(rows[i].k, 40'h00_0000_0000, 1'b0, 6'sd0, 1'b0);
			chk(xw.data, rows[i].exp);
			chk({xw.valid, xw.addr}, 17'h1_0040);
		end
		$display("store table done");
		// Forty-bit clipping, then a software clear of the sticky flag.
		axw(OFS_CFG, 32'h0000_0080);
		run_op(OP_ADD, 40'h7F_FFFF_FFFF, 1'b1, 6'sd0, 1'b0);
		run_op(OP_ADD, 40'h00_0000_0001, 1'b0, 6'sd0, 1'b0);
		chk(stat, 6'h35);
		axr(OFS_ACCA_HI);
		chk(rdat, 32'h0000_007F);
		axw(OFS_STAT, 32'h0000_0004);
		chk(stat, 6'h11);
		// Thirty-two-bit clipping never shows guard overflow.
		axw(OFS_CFG, 32'h0000_0090);
		run_op(OP_ADD, 40'h00_7FFF_FFFF, 1'b1, 6'sd0, 1'b0);
		run_op(OP_ADD, 40'h00_0000_0001, 1'b0, 6'sd0, 1'b0);
		chk(stat, 6'h24);
		axr(OFS_ACCA_LO);
		chk(rdat, 32'h7FFF_FFFF);
		$display("saturation test done");
		// Unclipped wrap with the fatal trap enabled.
		axw(OFS_STAT, 32'h0000_0004);
		axw(OFS_CFG, 32'h0000_0000);
		axw(OFS_TRAP, 32'h0000_0004);
		run_op(OP_ADD, 40'h7F_FFFF_FFFF, 1'b1, 6'sd0, 1'b0);
		run_op(OP_ADD, 40'h00_0000_0001, 1'b0, 6'sd0, 1'b0);
		chk(trap, 1'b1);
		chk(stat, 6'h35);
		axr(OFS_ACCA_HI);
		chk(rdat, 32'h0000_0080);
		// Only B saturates; a clear of its clip flag in the cycle of its overflow must lose.
		axw(OFS_CFG, 32'h0000_0060);
		axw(OFS_TRAP, 32'h0000_0002);
		op.target_b <= 1'b1;
		run_op(OP_ADD, 40'h7F_FFFF_FFFF, 1'b1, 6'sd0, 1'b0);
		fork
			axw(OFS_STAT, 32'h0000_0008);
			begin
				@(posedge aclk);
				run_op(OP_ADD, 40'h00_0000_0001, 1'b0, 6'sd0, 1'b0);
				chk(trap, 1'b1);
			end
		join
		op.target_b <= 1'b0;
		chk(stat, 6'h3F);
		// Subtract with indirect write-back of the other accumulator, rounded and clipped.
		axw(OFS_WBPTR, 32'h0000_0100);
		run_op(OP_ADD, 40'h00_0000_0005, 1'b1, 6'sd0, 1'b0);
		run_op(OP_SUB, 40'h00_0000_0003, 1'b0, 6'sd0, 1'b1);
		axr(OFS_WBPTR);
		chk(rdat, 32'h0000_0102);
		chk({la, ld}, 32'h0100_7FFF);
		axr(OFS_ACCA_LO);
		chk(rdat, 32'h0000_0002);
		$display("trap and write-back test done");
		// X bus data shifted right then left.
		run_op(OP_SHIFT, 40'h00_0000_0000, 1'b0, 6'sd4, 1'b0);
		chk({sh.valid, sh.data, sh.word}, {1'b1, 56'h00_0123_0000_0123});
		run_op(OP_SHIFT, 40'h00_0000_0000, 1'b0, -6'sd4, 1'b0);
		chk({sh.valid, sh.data, sh.word}, {1'b1, 56'h00_0001_2300_2300});
		axr(8'h40);
		chk({resp, rdat}, {RESP_SLVERR, 32'h0000_0000});
		// Accumulators are read-only on the register bus.
		axw(OFS_ACCA_LO, 32'h0000_0001);
		chk(bresp, RESP_SLVERR);
		$display("shift and unmapped test done");
		wrap_up();
	end
	// A hang is cut off far beyond the fewer than two hundred cycles the tests need.
	initial begin
		#2_000_000;
		fail_count++;
		wrap_up();
	end
endmodule // testbench
